// ---- oic_regs.svh ----
// Purpose: Register map and timing constants for the inhibit control pin.
// Assumes: 40 MHz core clock, word registers on a plain strobe port.
// Notes: Offsets are byte addresses of 32-bit words.
`ifndef OIC_REGS_SVH
`define OIC_REGS_SVH
`define OIC_ADDR_CTRL 8'h00
`define OIC_ADDR_CMD 8'h04
`define OIC_ADDR_STAT 8'h08
`define OIC_ADDR_IRQ_ST 8'h0C
`define OIC_ADDR_IRQ_MASK 8'h10
`define OIC_ADDR_PWM_PER 8'h14
`define OIC_ADDR_PWM_HI 8'h18
`define OIC_CTRL_FUNC_LSB 0
`define OIC_CTRL_INV 2
`define OIC_CTRL_LATCH 3
`define OIC_CTRL_OUT_LSB 4
`define OIC_CMD_ON 0
`define OIC_CMD_OFF 1
`define OIC_CMD_CLR_PROT 2
`define OIC_IRQ_INH_RISE 0
`define OIC_IRQ_LATCH_TRIP 1
`define OIC_IRQ_IN_EDGE 2
`define OIC_CLK_MHZ 40
`define OIC_MIN_LOW_US 30
`define OIC_MIN_LOW_CYC (`OIC_MIN_LOW_US * `OIC_CLK_MHZ)
`define OIC_CNT_W 16
`define OIC_ZERO32 32'h0000_0000
`endif

// ---- oic_pkg.sv ----
// Purpose: Types shared by the inhibit control pin design.
// Assumes: Used together with oic_regs.svh.
// Notes: Function and output source encodings, control word and interrupt bit structs.
package oic_pkg;
   typedef enum logic [1:0] {
      OIC_FN_INHIBIT,
      OIC_FN_INPUT,
      OIC_FN_OUTPUT,
      OIC_FN_RSVD
   } oic_func_t;
   typedef enum logic [1:0] {
      OIC_SRC_FALSE,
      OIC_SRC_TRUE,
      OIC_SRC_PWM,
      OIC_SRC_RSVD
   } oic_src_t;
   typedef struct packed {
      oic_src_t src;
      logic latch;
      logic invert;
      oic_func_t func;
   } oic_ctrl_t;
   typedef struct packed {
      logic in_edge;
      logic latch_trip;
      logic inh_rise;
   } oic_irq_t;
endpackage : oic_pkg

// ---- oic_pwm.sv ----
// Purpose: PWM generator for the pin output function.
// Assumes: Period and high time in core clock cycles.
// Notes: A high time at or above the period gives a steady high.
`timescale 1ns/1ps
`include "oic_regs.svh"
module oic_pwm
   import oic_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic i_enable,
   input wire logic [31:0] i_period,
   input wire logic [31:0] i_high,
   output logic o_pwm
);
   logic [31:0] cnt_reg;
   logic [31:0] cnt_next;
   logic pwm_reg;
   logic pwm_next;

   // Free count wraps at the period; restarts when disabled
   always_comb begin
      cnt_next = cnt_reg + 32'h0000_0001;
      if (!i_enable || cnt_next >= i_period) begin
         cnt_next = `OIC_ZERO32;
      end
      pwm_next = i_enable && (cnt_next < i_high);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         cnt_reg <= `OIC_ZERO32;
         pwm_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_next;
         pwm_reg <= pwm_next;
      end
   end

   assign o_pwm = pwm_reg;
endmodule : oic_pwm

// ---- oic_pin.sv ----
// Purpose: Multipurpose inhibit / input / output control pin.
// Assumes: One core clock; pin is tri-state style with three signals.
// Notes: Output enable low means the block drives the pin.
// Operation
// - Pin function is one of inhibit, level input or digital output.
// - Polarity option inverts pin level for input and output.
// - Inhibit function lets the pin govern the supply output.
// - Inhibit offers level-following or latched sub-mode.
// - Undriven pin reads high and, unless inverted, leaves output alone.
// - Level mode: low pin forces output to zero, on indicator stays.
// - Level mode: pin back high restores output automatically.
// - Inverted: high pin level is the inhibiting condition.
// - Active level inhibit disables output and shows inhibit flag.
// - Latched: pulse while on switches output state off.
// - After latched trip output stays off until operator turns on.
// - Trip sets protection state; restart only after it is cleared.
// - Input function samples the pin as an external level.
// - Output, not inverted: true drives pin low.
// - Output, not inverted: false drives pin high.
// - Output inverted: true goes high, false goes low.
// - Output can emit PWM with settable frequency and duty.
`timescale 1ns/1ps
`include "oic_regs.svh"
module oic_pin
   import oic_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [31:0] o_rdata,
   input wire logic i_pin,
   output logic o_pin,
   output logic o_pin_oe_n,
   output logic o_output_on,
   output logic o_output_gate,
   output logic o_onoff_indicator,
   output logic o_inhibit_active_indication,
   output logic o_latched_shutdown_indication,
   output logic o_irq
);
   // On/off state; protection is left only by an explicit clear
   typedef enum logic [1:0] {
      OIC_ST_OFF,
      OIC_ST_ON,
      OIC_ST_PROT
   } oic_state_t;

   oic_ctrl_t ctrl_reg;
   oic_ctrl_t ctrl_next;
   logic [31:0] per_reg;
   logic [31:0] per_next;
   logic [31:0] hi_reg;
   logic [31:0] hi_next;
   oic_irq_t ist_reg;
   oic_irq_t ist_next;
   oic_irq_t imask_reg;
   oic_irq_t imask_next;
   logic [31:0] rdata_reg;
   logic [31:0] rdata_next;
   oic_state_t st_reg;
   oic_state_t st_next;
   logic sync1_reg;
   logic sync2_reg;
   logic lvl_reg;
   logic lvl_next;
   logic [`OIC_CNT_W-1:0] low_cnt_reg;
   logic [`OIC_CNT_W-1:0] low_cnt_next;
   logic armed_reg;
   logic armed_next;
   logic pin_reg;
   logic pin_next;
   logic oe_n_reg;
   logic oe_n_next;
   logic gate_reg;
   logic gate_next;
   logic inh_reg;
   logic inh_next;
   logic irq_reg;
   logic irq_next;
   logic pwm;
   logic pwm_en;
   logic logic_lvl;
   logic pulse_ok;
   logic inh_level;
   logic cmd_on;
   logic cmd_off;
   logic cmd_clr;

   // Two flop synchroniser; first stage read only by the second
   // Both stages reset high, the idle level of the pulled-up pin
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
      end else begin
         sync1_reg <= i_pin;
         sync2_reg <= sync1_reg;
      end
   end

   // PWM runs only while selected so it restarts at a known phase
   assign pwm_en = ctrl_reg.func == OIC_FN_OUTPUT &&
                   ctrl_reg.src == OIC_SRC_PWM;

   oic_pwm u_pwm (
      .i_core_clk (i_core_clk),
      .i_sys_rst (i_sys_rst),
      .i_enable (pwm_en),
      .i_period (per_reg),
      .i_high (hi_reg),
      .o_pwm (pwm)
   );

   // Logical pin level: active means low pin unless inverted
   assign logic_lvl = ctrl_reg.invert ? sync2_reg : ~sync2_reg;
   assign inh_level = ctrl_reg.func == OIC_FN_INHIBIT && !ctrl_reg.latch &&
                      lvl_reg;
   // Qualified pulse: active long enough, armed from an idle level
   assign pulse_ok = armed_reg && lvl_reg &&
                     low_cnt_reg == `OIC_CNT_W'(`OIC_MIN_LOW_CYC - 1);
   // Command bits decode one each; several may be set at once
   assign cmd_on = i_wr && i_addr == `OIC_ADDR_CMD &&
                   i_wdata[`OIC_CMD_ON];
   assign cmd_off = i_wr && i_addr == `OIC_ADDR_CMD &&
                    i_wdata[`OIC_CMD_OFF];
   assign cmd_clr = i_wr && i_addr == `OIC_ADDR_CMD &&
                    i_wdata[`OIC_CMD_CLR_PROT];

   // Level filter and pulse width counter
   // Counter parks at the trip count; re-armed only by an idle pin
   always_comb begin
      lvl_next = logic_lvl;
      low_cnt_next = low_cnt_reg;
      armed_next = armed_reg;
      if (!lvl_reg) begin
         low_cnt_next = '0;
         armed_next = 1'b1;
      end else if (low_cnt_reg != `OIC_CNT_W'(`OIC_MIN_LOW_CYC - 1)) begin
         low_cnt_next = low_cnt_reg + `OIC_CNT_W'(1);
      end else begin
         armed_next = 1'b0; // One trip per pulse
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         lvl_reg <= 1'b0;
         low_cnt_reg <= '0;
         armed_reg <= 1'b0;
      end else begin
         lvl_reg <= lvl_next;
         low_cnt_reg <= low_cnt_next;
         armed_reg <= armed_next;
      end
   end

   // On/off state machine; protection blocks a restart until cleared
   always_comb begin
      st_next = st_reg;
      case (st_reg)
         OIC_ST_OFF: begin
            if (cmd_on) begin
               st_next = OIC_ST_ON;
            end
         end
         OIC_ST_ON: begin
            // A trip outranks an off command in the same cycle
            if (ctrl_reg.func == OIC_FN_INHIBIT && ctrl_reg.latch &&
                pulse_ok) begin
               st_next = OIC_ST_PROT;
            end else if (cmd_off) begin
               st_next = OIC_ST_OFF;
            end
         end
         OIC_ST_PROT: begin
            // Turn-on requests ignored here, never auto restore
            if (cmd_clr) begin
               st_next = OIC_ST_OFF;
            end
         end
         default: begin
            st_next = OIC_ST_OFF;
         end
      endcase
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         st_reg <= OIC_ST_OFF;
      end else begin
         st_reg <= st_next;
      end
   end

   // Output gate and pin drive
   // Outside the output function the pin is released, never fought
   always_comb begin
      gate_next = st_next == OIC_ST_ON && !inh_level;
      inh_next = inh_level;
      pin_next = 1'b1;
      oe_n_next = 1'b1; // Released; pull up reads high
      if (ctrl_reg.func == OIC_FN_OUTPUT) begin
         oe_n_next = 1'b0;
         case (ctrl_reg.src)
            OIC_SRC_TRUE: pin_next = ctrl_reg.invert;
            OIC_SRC_PWM: pin_next = ctrl_reg.invert ~^ pwm;
            default: pin_next = ~ctrl_reg.invert;
         endcase
      end
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         gate_reg <= 1'b0;
         inh_reg <= 1'b0;
         pin_reg <= 1'b1;
         oe_n_reg <= 1'b1;
      end else begin
         gate_reg <= gate_next;
         inh_reg <= inh_next;
         pin_reg <= pin_next;
         oe_n_reg <= oe_n_next;
      end
   end

   // Register writes; sticky set wins over write-one-to-clear
   always_comb begin
      ctrl_next = ctrl_reg;
      per_next = per_reg;
      hi_next = hi_reg;
      imask_next = imask_reg;
      ist_next = ist_reg;
      if (i_wr) begin
         if (i_addr == `OIC_ADDR_CTRL) begin
            ctrl_next = oic_ctrl_t'(i_wdata[$bits(oic_ctrl_t)-1:0]);
         end else if (i_addr == `OIC_ADDR_IRQ_ST) begin
            ist_next = ist_reg & ~oic_irq_t'(i_wdata[$bits(oic_irq_t)-1:0]);
         end else if (i_addr == `OIC_ADDR_IRQ_MASK) begin
            imask_next = oic_irq_t'(i_wdata[$bits(oic_irq_t)-1:0]);
         end else if (i_addr == `OIC_ADDR_PWM_PER) begin
            per_next = i_wdata;
         end else if (i_addr == `OIC_ADDR_PWM_HI) begin
            hi_next = i_wdata;
         end
      end
      // Events land after the write, so a same-cycle clear loses
      if (inh_level && !inh_reg) begin
         ist_next.inh_rise = 1'b1;
      end
      if (st_reg == OIC_ST_ON && st_next == OIC_ST_PROT) begin
         ist_next.latch_trip = 1'b1;
      end
      if (ctrl_reg.func == OIC_FN_INPUT && lvl_next != lvl_reg) begin
         ist_next.in_edge = 1'b1;
      end
      irq_next = |(ist_next & imask_next);
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         ctrl_reg <= '0;
         per_reg <= `OIC_ZERO32;
         hi_reg <= `OIC_ZERO32;
         imask_reg <= '0;
         ist_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         ctrl_reg <= ctrl_next;
         per_reg <= per_next;
         hi_reg <= hi_next;
         imask_reg <= imask_next;
         ist_reg <= ist_next;
         irq_reg <= irq_next;
      end
   end

   // Read mux; unmapped addresses read zero
   always_comb begin
      rdata_next = `OIC_ZERO32;
      if (i_rd) begin
         if (i_addr == `OIC_ADDR_CTRL) begin
            rdata_next = {26'h000_0000, ctrl_reg};
         end else if (i_addr == `OIC_ADDR_STAT) begin
            rdata_next = {26'h000_0000, lvl_reg, st_reg == OIC_ST_PROT,
                          inh_reg, gate_reg, st_reg == OIC_ST_ON,
                          sync2_reg};
         end else if (i_addr == `OIC_ADDR_IRQ_ST) begin
            rdata_next = {29'h0000_0000, ist_reg};
         end else if (i_addr == `OIC_ADDR_IRQ_MASK) begin
            rdata_next = {29'h0000_0000, imask_reg};
         end else if (i_addr == `OIC_ADDR_PWM_PER) begin
            rdata_next = per_reg;
         end else if (i_addr == `OIC_ADDR_PWM_HI) begin
            rdata_next = hi_reg;
         end
      end
   end

   // Read data stands one cycle, then falls back to zero
   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         rdata_reg <= `OIC_ZERO32;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   // Indicator flops: on lamp follows state, not the inhibit gate
   logic on_ind_reg;
   logic on_ind_next;
   logic prot_ind_reg;
   logic prot_ind_next;

   // Lamps copy the next state so they move with the state flop
   always_comb begin
      on_ind_next = st_next == OIC_ST_ON;
      prot_ind_next = st_next == OIC_ST_PROT;
   end

   always_ff @(posedge i_core_clk) begin
      if (i_sys_rst) begin
         on_ind_reg <= 1'b0;
         prot_ind_reg <= 1'b0;
      end else begin
         on_ind_reg <= on_ind_next;
         prot_ind_reg <= prot_ind_next;
      end
   end

   assign o_rdata = rdata_reg;
   assign o_pin = pin_reg;
   assign o_pin_oe_n = oe_n_reg;
   assign o_output_on = on_ind_reg;
   assign o_output_gate = gate_reg;
   assign o_onoff_indicator = on_ind_reg;
   assign o_inhibit_active_indication = inh_reg;
   assign o_latched_shutdown_indication = prot_ind_reg;
   assign o_irq = irq_reg;
endmodule : oic_pin

// ---- oic_pin_monitor.sv ----
// Purpose: Port checker for the inhibit control pin.
// Assumes: Control word mirrored from bus writes.
// Notes: A few cycles of slack cover pin sync.
`timescale 1ns/1ps
`include "oic_regs.svh"
module oic_pin_monitor
   import oic_pkg::*;
(
   input wire logic i_core_clk,
   input wire logic i_sys_rst,
   input wire logic [7:0] i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic i_pin,
   input wire logic o_pin,
   input wire logic o_pin_oe_n,
   input wire logic o_output_on,
   input wire logic o_output_gate,
   input wire logic o_onoff_indicator,
   input wire logic o_inhibit_active_indication,
   input wire logic o_latched_shutdown_indication,
   input wire logic o_irq
);
   logic [5:0] ctl_reg, ctl_next;
   logic [2:0] age_reg, age_next;
   logic st, lvl_n, lvl_i, drv;
   // Age since last control write; settle time before judging
   always_comb begin
      ctl_next = ctl_reg;
      age_next = (age_reg == 3'h7) ? age_reg : age_reg + 3'h1;
      if (i_wr && i_addr == `OIC_ADDR_CTRL) begin
         ctl_next = i_wdata[5:0];
         age_next = 3'h0;
      end
   end
   always_ff @(posedge i_core_clk) begin
      ctl_reg <= i_sys_rst ? 6'h00 : ctl_next;
      age_reg <= i_sys_rst ? 3'h0 : age_next;
   end
   assign st = age_reg >= 3'h4;
   assign lvl_n = st && ctl_reg[3:0] == 4'h0;
   assign lvl_i = st && ctl_reg[3:0] == 4'h4;
   assign drv = st && ctl_reg[1:0] == 2'h2 && !ctl_reg[5];
   default clocking cb @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);
   sequence low_s;
      (lvl_n && !i_pin && o_output_on) [*6];
   endsequence
   sequence high_s;
      (lvl_n && i_pin && o_output_on) [*6];
   endsequence
   a_rdata_idle_zero: assert property (!i_rd |=> o_rdata == `OIC_ZERO32)
      else $error("read data not zero");
   a_lamp_tracks_on: assert property (o_onoff_indicator == o_output_on)
      else $error("lamp differs from on state");
   a_gate_needs_on: assert property (o_output_gate |-> o_output_on)
      else $error("gate open while off");
   a_low_pin_blocks: assert property (low_s |-> !o_output_gate
      && o_inhibit_active_indication) else $error("low pin not inhibiting");
   a_high_pin_frees: assert property (high_s |-> o_output_gate)
      else $error("output not restored");
   a_invert_high_blocks: assert property ((lvl_i && i_pin) [*6]
      |-> !o_output_gate) else $error("inverted high not inhibiting");
   a_no_auto_on: assert property ($rose(o_output_on) |-> $past(i_wr)
      && $past(i_addr) == `OIC_ADDR_CMD) else $error("on without command");
   a_prot_keeps_off: assert property (o_latched_shutdown_indication
      |-> !o_output_on) else $error("on during protection");
   a_plain_level: assert property (drv && !ctl_reg[2]
      |-> o_pin == !ctl_reg[4] && !o_pin_oe_n) else $error("pin level");
   a_invert_level: assert property (drv && ctl_reg[2]
      |-> o_pin == ctl_reg[4]) else $error("inverted pin level");
   a_release_pin: assert property (st && ctl_reg[1:0] != 2'h2
      |-> o_pin_oe_n) else $error("pin driven outside output");
endmodule : oic_pin_monitor
bind oic_pin oic_pin_monitor oic_pin_monitor_i (.i_core_clk, .i_sys_rst,
   .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pin, .o_pin, .o_pin_oe_n,
   .o_output_on, .o_output_gate, .o_onoff_indicator,
   .o_inhibit_active_indication, .o_latched_shutdown_indication, .o_irq);

// ---- oic_src_model.sv ----
// Purpose: External source on the control pin.
// Assumes: Pin has a pull-up to the high level.
// Notes: Design drive wins while its enable is low.
`timescale 1ns/1ps
module oic_src_model (
   input wire logic i_core_clk,
   input wire logic i_pin_drv,
   input wire logic i_pin_oe_n,
   output logic o_wire
);
   logic en = 1'b0;
   logic lvl = 1'b1;
   // Released wire floats up, never keeps the last level
   assign o_wire = !i_pin_oe_n ? i_pin_drv : (en ? lvl : 1'b1);
   task automatic drive(input logic l);
      @(posedge i_core_clk);
      en <= 1'b1;
      lvl <= l;
   endtask : drive
   task automatic off;
      @(posedge i_core_clk);
      en <= 1'b0;
   endtask : off
   // Low pulse; callers give at least 1200 cycles unless refused on purpose
   task automatic pulse(input int n);
      drive(1'b0);
      repeat (n) @(posedge i_core_clk);
      en <= 1'b0;
   endtask : pulse
endmodule : oic_src_model

// ---- oic_pin_tb.sv ----
// Purpose: Self-checking bench for the inhibit control pin.
// Assumes: 40 MHz clock, register map of oic_regs.svh.
// Notes: Wire level resolved by the source model.
`timescale 1ns/1ps
`include "oic_regs.svh"
module oic_pin_tb
   import oic_pkg::*;
;
   logic i_core_clk, i_sys_rst, i_wr, i_rd, i_pin, o_pin, o_pin_oe_n;
   logic o_output_on, o_output_gate, o_onoff_indicator, o_irq;
   logic o_inhibit_active_indication, o_latched_shutdown_indication;
   logic [7:0] i_addr;
   logic [31:0] i_wdata, o_rdata, d;
   int err_total, cmp_count, cyc, k, n;
   oic_pin oic_pin_i (.i_core_clk, .i_sys_rst, .i_addr, .i_wdata, .i_wr,
      .i_rd, .o_rdata, .i_pin, .o_pin, .o_pin_oe_n, .o_output_on,
      .o_output_gate, .o_onoff_indicator, .o_inhibit_active_indication,
      .o_latched_shutdown_indication, .o_irq);
   oic_src_model oic_src_model_i (.i_core_clk, .i_pin_drv(o_pin),
      .i_pin_oe_n(o_pin_oe_n), .o_wire(i_pin));
   initial begin
      i_core_clk = 1'b0;
      forever #12.5 i_core_clk = ~i_core_clk;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge i_core_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= v;
      @(posedge i_core_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [7:0] a);
      @(posedge i_core_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_core_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd
   task automatic w(input int c);
      repeat (c) @(posedge i_core_clk);
      #1;
   endtask : w
   task automatic chk(input string s, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask : chk
   task automatic wrap_up;
      $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : wrap_up
   // Hang guard; the run needs about 3000 cycles
   always @(posedge i_core_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         err_total++;
         wrap_up();
      end
   end
   initial begin
      i_sys_rst = 1'b1;
      i_wr = 1'b0;
      i_rd = 1'b0;
      i_addr = 8'h00;
      i_wdata = 32'h0000_0000;
      repeat (20) @(posedge i_core_clk);
      i_sys_rst <= 1'b0;
      w(4);
      // Reset state, an unmapped hole, status word
      wr(8'h1C, 32'hFFFF_FFFF);
      rd(8'h1C);
      chk("hole", 32'h0000_0000, d);
      rd(`OIC_ADDR_CTRL);
      chk("ctrl", 32'h0000_0000, d);
      rd(`OIC_ADDR_STAT);
      chk("stat", 32'h0000_0001, d & 32'h0000_001F);
      $display("test reset done");
      // Level-following inhibit, plain then inverted
      wr(`OIC_ADDR_CMD, 32'h0000_0001);
      w(6);
      chk("gate", 1'b1, o_output_gate);
      oic_src_model_i.drive(1'b0);
      w(8);
      chk("gate low", 1'b0, o_output_gate);
      chk("lamp", 1'b1, o_onoff_indicator);
      chk("inh", 1'b1, o_inhibit_active_indication);
      chk("irq masked", 1'b0, o_irq);
      oic_src_model_i.off();
      w(8);
      chk("restore", 1'b1, o_output_gate);
      wr(`OIC_ADDR_CTRL, 32'h0000_0004);
      w(8);
      chk("inv high", 1'b0, o_output_gate);
      oic_src_model_i.drive(1'b0);
      w(8);
      chk("inv low", 1'b1, o_output_gate);
      oic_src_model_i.off();
      $display("test level done");
      // Latched mode: short pulse refused, full pulse trips
      wr(`OIC_ADDR_CTRL, 32'h0000_0008);
      wr(`OIC_ADDR_IRQ_MASK, 32'h0000_0002);
      w(6);
      oic_src_model_i.pulse(1100);
      w(6);
      chk("short", 1'b1, o_output_on);
      oic_src_model_i.pulse(1300);
      w(2);
      chk("trip", 1'b0, o_output_on);
      chk("trip lamp", 1'b0, o_onoff_indicator);
      chk("prot", 1'b1, o_latched_shutdown_indication);
      chk("irq", 1'b1, o_irq);
      wr(`OIC_ADDR_CMD, 32'h0000_0001);
      w(4);
      chk("on in prot", 1'b0, o_output_on);
      wr(`OIC_ADDR_CMD, 32'h0000_0004);
      w(4);
      chk("cleared", 1'b0, o_latched_shutdown_indication);
      chk("no auto", 1'b0, o_output_on);
      rd(`OIC_ADDR_IRQ_ST);
      chk("trip st", 32'h0000_0003, d & 32'h0000_0007);
      wr(`OIC_ADDR_IRQ_ST, 32'h0000_0007);
      w(2);
      chk("irq clr", 1'b0, o_irq);
      wr(`OIC_ADDR_CMD, 32'h0000_0001);
      w(4);
      chk("restart", 1'b1, o_output_on);
      $display("test latch done");
      // Output levels for both polarities, then PWM and input
      for (k = 0; k < 4; k++) begin
         wr(`OIC_ADDR_CTRL, 32'h0000_0002 | (k[0] << 4) | (k[1] << 2));
         w(4);
         chk("pin", !(k[0] ^ k[1]), o_pin);
         chk("oe_n", 1'b0, o_pin_oe_n);
      end
      wr(`OIC_ADDR_PWM_PER, 32'h0000_000A);
      wr(`OIC_ADDR_PWM_HI, 32'h0000_0003);
      wr(`OIC_ADDR_CTRL, 32'h0000_0022);
      w(20);
      n = 0;
      repeat (100) begin
         w(1);
         n += (o_pin === 1'b0);
      end
      chk("pwm", 32'h0000_001E, n);
      wr(`OIC_ADDR_CTRL, 32'h0000_0001);
      oic_src_model_i.drive(1'b0);
      w(6);
      chk("in oe_n", 1'b1, o_pin_oe_n);
      rd(`OIC_ADDR_STAT);
      chk("in lvl", 32'h0000_0020, d & 32'h0000_0021);
      wr(`OIC_ADDR_CTRL, 32'h0000_0005);
      w(4);
      rd(`OIC_ADDR_STAT);
      chk("in inv", 32'h0000_0000, d & 32'h0000_0021);
      rd(`OIC_ADDR_IRQ_ST);
      chk("in edge", 32'h0000_0004, d & 32'h0000_0004);
      oic_src_model_i.off();
      $display("test output done");
      wrap_up();
   end
endmodule : oic_pin_tb
